// [shared/acr_pkg.sv]
// Constants, field layouts and types for the converter mask and mode register bank.
// Assumes a 32-bit classic Wishbone register bus clocked by sys_clk.
package acr_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          DATA_W          = 32;
   localparam logic [31:0] MASK_REG_ADDR   = 32'hFFFF0504;
   localparam logic [31:0] MODE_REG_ADDR   = 32'hFFFF0508;
   localparam logic [7:0]  MASK_RESET      = 8'h00;
   localparam logic [7:0]  MODE_RESET      = 8'h03;
   // Mask bits that have a source behind them; 7, 5 and 2 stay unwired
   localparam logic [7:0]  MASK_LIVE_BITS  = 8'h5B;
   localparam int          BIT_PRI_READY   = 0;
   localparam int          BIT_AUX_READY   = 1;
   localparam int          BIT_PRI_OVR     = 3;
   localparam int          BIT_PRI_THR     = 4;
   localparam int          BIT_ACC_THR     = 6;
   localparam int          BIT_CLK_SEL     = 7;
   localparam int          BIT_LOW_PWR_EN  = 5;
   localparam int          PWR_MODE_LSB    = 3;
   localparam int          OP_MODE_LSB     = 0;
   localparam int          SYS_CLK_HZ      = 100_000_000;
   localparam int          FAST_CONV_HZ    = 512_000;
   localparam int          SLOW_CONV_HZ    = 131_000;
   // Half-period counts, rounded down so the clock is never slower than stated
   localparam int          FAST_HALF_CYC   = SYS_CLK_HZ / (2 * FAST_CONV_HZ);
   localparam int          SLOW_HALF_CYC   = SYS_CLK_HZ / (2 * SLOW_CONV_HZ);
   localparam int          DIV_W           = 10;

   typedef enum logic [1:0] {
      ACR_PWR_NORMAL   = 2'b00,
      ACR_PWR_LOW      = 2'b01,
      ACR_PWR_NORMAL_B = 2'b10,
      ACR_PWR_LOW_PLUS = 2'b11
   } acr_pwr_t;

   typedef enum logic [2:0] {
      ACR_OP_POWER_DOWN = 3'b000,
      ACR_OP_CONTINUOUS = 3'b001,
      ACR_OP_SINGLE     = 3'b010,
      ACR_OP_IDLE       = 3'b011,
      ACR_OP_SELF_OFS   = 3'b100,
      ACR_OP_SELF_GAIN  = 3'b101,
      ACR_OP_SYS_ZERO   = 3'b110,
      ACR_OP_SYS_FULL   = 3'b111
   } acr_op_t;
endpackage

// [shared/acr_mode_if.sv]
// Decoded mode settings passed from the register file to the clock divider.
// Assumes both ends run on sys_clk.
interface acr_mode_if;
   logic clkSelFast;
   logic convClk;
   modport regs (output clkSelFast, input convClk);
   modport div  (input clkSelFast, output convClk);
endinterface

// [rtl/acr_conv_clk_div.sv]
// Conversion clock divider: produces a 512 kHz or 131 kHz square wave.
// Assumes sys_clk at 100 MHz; output is a registered level on sys_clk.
module acr_conv_clk_div
   import acr_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic clkEn,
   // Mode link
   acr_mode_if.div   modeLink
);
   import acr_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] count;
      logic             level;
   } acr_div_state_t;

   acr_div_state_t s_q;
   acr_div_state_t s_d;
   logic [DIV_W-1:0] limit;

   // Refuse rates that the counter cannot reach
   if (SLOW_HALF_CYC >= (1 << DIV_W) || FAST_HALF_CYC < 1) begin : g_div_range
      $error("Divider counter too narrow for chosen rates");
   end

   always_comb begin
      s_d   = s_q;
      limit = modeLink.clkSelFast ? DIV_W'(FAST_HALF_CYC - 1)
                                  : DIV_W'(SLOW_HALF_CYC - 1);
      // A rate change acts on the current half period; no runt beyond that one half
      if (s_q.count >= limit) begin
         s_d.count = '0;
         s_d.level = ~s_q.level;
      end else begin
         s_d.count = s_q.count + DIV_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign modeLink.convClk = s_q.level;

   chk_slow_half_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && !modeLink.clkSelFast && s_q.count == DIV_W'(SLOW_HALF_CYC - 1))
      |=> s_q.count == '0 && s_q.level != $past(s_q.level))
      else $error("Slow divider reloaded wrongly");
endmodule

// [rtl/acr_irq_gate.sv]
// Interrupt gate: ANDs the status flags with the mask and ORs them to one request.
// Assumes status flags come from logic on sys_clk.
module acr_irq_gate
   import acr_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       clkEn,
   // Sources
   input  wire logic [7:0] statusFlags,
   input  wire logic [7:0] irqMask,
   // Request
   output logic            irqReq
);
   import acr_pkg::*;

   typedef struct packed {
      logic req;
   } acr_irq_state_t;

   acr_irq_state_t s_q;
   acr_irq_state_t s_d;

   always_comb begin
      s_d = s_q;
      // Reserved mask positions are dropped here, so they never raise a request
      s_d.req = |(statusFlags & irqMask & MASK_LIVE_BITS);
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign irqReq = s_q.req;

   chk_ready_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
      clkEn ##0 (statusFlags[BIT_PRI_READY] && irqMask[BIT_PRI_READY]) |=> irqReq)
      else $error("Primary ready did not raise request");
   chk_overrange_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && (statusFlags & irqMask & MASK_LIVE_BITS) == 8'h00) |=> !irqReq)
      else $error("Request raised with every source masked");
   chk_threshold_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && statusFlags[BIT_ACC_THR] && irqMask[BIT_ACC_THR]) |=> irqReq)
      else $error("Accumulator threshold did not raise request");
   chk_reserved_inert: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && (statusFlags & irqMask & MASK_LIVE_BITS) == 8'h00
       && (statusFlags & irqMask) != 8'h00) |=> !irqReq)
      else $error("Reserved mask bit raised request");
endmodule

// [rtl/acr_adc_regs.sv]
// Converter mask and mode register bank with classic Wishbone slave.
// Assumes a single-clock Wishbone master and status flags on sys_clk.
//
// Behaviour
// - Mask register resets to zero.
// - Mask bits align with low status bits.
// - Ready flags request interrupt when enabled.
// - Threshold flags request interrupt when enabled.
// - Overrange flag requests interrupt via bit 3.
// - Mask bits 7, 5, 2 have no effect.
// - Mode register 8-bit, resets to 0x03.
// - Bit 7 picks 512 or 131 kHz.
// - Low power enable ignored in normal mode.
// - Bits 4:3 decode normal or low power.
// - Power mode 11 is low power plus.
// - Bits 2:0 decode operation mode.
module acr_adc_regs
   import acr_pkg::*;
(
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic                 clkEn,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ADDR_W-1:0]    wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [DATA_W-1:0]    wb_dat_i,
   output logic      [DATA_W-1:0]    wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      wb_err_o,
   // Converter status
   input  wire logic [7:0]           statusFlags,
   // Converter controls
   output logic                      irqReq,
   output logic                      conversionClock,
   output logic                      clkSelFast,
   output logic                      lowPowerActive,
   output logic                      lowPowerPlus,
   output acr_pkg::acr_op_t          opMode
);
   import acr_pkg::*;

   typedef struct packed {
      logic [7:0]        mask;
      logic [7:0]        mode;
      logic              ack;
      logic              err;
      logic [DATA_W-1:0] rdata;
      logic              lpActive;
      logic              lpPlus;
   } acr_reg_state_t;

   acr_reg_state_t s_q;
   acr_reg_state_t s_d;
   acr_mode_if     modeLink ();
   logic           req;
   logic           hitMask;
   logic           hitMode;
   acr_pwr_t       pwr;

   function automatic logic pwr_is_low(input logic [1:0] cfg);
      return cfg == ACR_PWR_LOW || cfg == ACR_PWR_LOW_PLUS;
   endfunction

   assign req     = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
   assign hitMask = wb_adr_i == MASK_REG_ADDR;
   assign hitMode = wb_adr_i == MODE_REG_ADDR;
   assign pwr     = acr_pwr_t'(s_q.mode[PWR_MODE_LSB +: 2]);

   always_comb begin
      s_d       = s_q;
      s_d.ack   = 1'b0;
      s_d.err   = 1'b0;
      // One wait state: ack comes the cycle after the request is seen
      // Writes land on the edge at which the master sees ack, request still standing
      if (wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i && wb_sel_i[0]) begin
         if (hitMask)
            s_d.mask = wb_dat_i[7:0];
         else if (hitMode)
            s_d.mode = wb_dat_i[7:0];
      end
      if (req) begin
         if (hitMask || hitMode) begin
            s_d.ack = 1'b1;
            s_d.rdata = {24'h000000, hitMask ? s_q.mask : s_q.mode};
         end else begin
            s_d.err   = 1'b1;
            s_d.rdata = '0;
         end
      end
      // Low power enable only counts when the power field selects low power
      s_d.lpActive = pwr_is_low(pwr) && s_q.mode[BIT_LOW_PWR_EN];
      s_d.lpPlus   = pwr == ACR_PWR_LOW_PLUS;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q      <= '0;
         s_q.mask <= MASK_RESET;
         s_q.mode <= MODE_RESET;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign modeLink.clkSelFast = s_q.mode[BIT_CLK_SEL];

   acr_conv_clk_div u_div (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .modeLink (modeLink.div)
   );

   acr_irq_gate u_irq (
      .sys_clk     (sys_clk),
      .reset_n     (reset_n),
      .clkEn       (clkEn),
      .statusFlags (statusFlags),
      .irqMask     (s_q.mask),
      .irqReq      (irqReq)
   );

   assign wb_dat_o        = s_q.rdata;
   assign wb_ack_o        = s_q.ack;
   assign wb_err_o        = s_q.err;
   assign conversionClock = modeLink.convClk;
   assign clkSelFast      = modeLink.clkSelFast;
   assign lowPowerActive  = s_q.lpActive;
   assign lowPowerPlus    = s_q.lpPlus;
   assign opMode          = acr_op_t'(s_q.mode[OP_MODE_LSB +: 3]);

   sequence seq_mask_write;
      clkEn && wb_cyc_i && wb_stb_i && wb_ack_o && hitMask && wb_we_i && wb_sel_i[0];
   endsequence

   sequence seq_mode_write;
      clkEn && wb_cyc_i && wb_stb_i && wb_ack_o && hitMode && wb_we_i && wb_sel_i[0];
   endsequence

   chk_mask_reset: assert property (@(posedge sys_clk)
      $rose(reset_n) |-> s_q.mask == MASK_RESET)
      else $error("Mask not zero after reset");
   chk_mode_reset: assert property (@(posedge sys_clk)
      $rose(reset_n) |-> s_q.mode == MODE_RESET)
      else $error("Mode not 0x03 after reset");
   chk_mask_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
      seq_mask_write |=> !wb_ack_o && s_q.mask == $past(wb_dat_i[7:0]))
      else $error("Mask write not stored at same bit positions");
   chk_lowpower_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && s_q.mode[PWR_MODE_LSB +: 2] == 2'b00) |=> !lowPowerActive)
      else $error("Low power active in normal mode");
   chk_plus_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (clkEn && s_q.mode[PWR_MODE_LSB +: 2] == 2'b10) |=> !lowPowerPlus && !lowPowerActive)
      else $error("Power field 10 not treated as normal");
   chk_opmode_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
      seq_mode_write |=> opMode == $past(wb_dat_i[OP_MODE_LSB +: 3])
      && clkSelFast == $past(wb_dat_i[BIT_CLK_SEL]))
      else $error("Mode fields misdecoded");
endmodule

// [tb/tb.sv]
// Self-checking bench for the converter mask and mode register bank.
// Assumes the bank's assertions live in its own files; sys_clk 100 MHz, clkEn high but one test.
module tb
   import acr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        e;
      logic        r;
      logic [31:0] d;
   } acr_tb_note_t;

   logic              sys_clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              clkEn   = 1'b1;
   logic              cyc     = 1'b0;
   logic              stb     = 1'b0;
   logic              we      = 1'b0;
   logic [31:0]       adr     = 32'h00000000;
   logic [31:0]       dat     = 32'h00000000;
   logic [3:0]        sel     = 4'h0;
   logic [7:0]        flags   = 8'h00;
   logic [31:0]       datO;
   logic              ack;
   logic              err;
   logic              irq;
   logic              convClk;
   logic              clkSel;
   logic              lpAct;
   logic              lpPlus;
   acr_op_t           opMode;
   int                failures       = 0;
   int                samplesChecked = 0;
   logic [31:0]       rng            = 32'h00000033;
   acr_tb_note_t      notes[$];
   acr_tb_note_t      note;
   logic [7:0]        m;
   int                h;
   logic              lvl;
   logic              irqHeld;

   acr_adc_regs dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err),
      .statusFlags(flags), .irqReq(irq), .conversionClock(convClk), .clkSelFast(clkSel),
      .lowPowerActive(lpAct), .lowPowerPlus(lpPlus), .opMode(opMode)
   );

   always #5 sys_clk = ~sys_clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Entered just after a rising edge; leaves one idle cycle behind it
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic e, input logic [31:0] expD);
      int n;
      notes.push_back('{e, !w, expD});
      rng = xs(rng);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         conclude();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge sys_clk);
   endtask

   // First toggle after a mode change may be partial, so callers use the second
   task automatic measHalf(output int hc);
      int   n;
      logic last;
      n    = 0;
      last = convClk;
      while (convClk === last && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      last = convClk;
      hc   = 0;
      while (convClk === last && hc < 2000) begin
         @(posedge sys_clk);
         hc++;
      end
      if (hc >= 2000) begin
         failures++;
         conclude();
      end
   endtask

   // Reply watcher: each ack or err retires the oldest note
   always @(posedge sys_clk) begin
      if (ack === 1'b1 || err === 1'b1) begin
         if (notes.size() == 0) begin
            failures++;
            $display("unexpected at %0t: reply with no pending request", $time);
         end else begin
            note = notes.pop_front();
            check({31'h0, err}, {31'h0, note.e});
            if (note.r && !note.e)
               check(datO, note.d);
         end
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      check({29'h0, opMode}, 32'h00000003);
      check({31'h0, clkSel}, 32'h00000000);
      wb(1'b0, MASK_REG_ADDR, 32'h0, 4'hF, 1'b0, 32'h00000000);
      wb(1'b0, MODE_REG_ADDR, 32'h0, 4'hF, 1'b0, 32'h00000003);
      $display("test reset values done");
      for (int b = 0; b < 8; b++) begin
         wb(1'b1, MASK_REG_ADDR, {rng[31:8], 8'h01 << b}, 4'hF, 1'b0, 32'h0);
         flags <= 8'h01 << b;
         repeat (3) @(posedge sys_clk);
         check({31'h0, irq}, {31'h0, b inside {0, 1, 3, 4, 6}});
         flags <= ~(8'h01 << b);
         repeat (3) @(posedge sys_clk);
         check({31'h0, irq}, 32'h00000000);
         wb(1'b1, MASK_REG_ADDR, {24'h0, ~(8'h01 << b)}, 4'hF, 1'b0, 32'h0);
         flags <= 8'h01 << b;
         repeat (3) @(posedge sys_clk);
         check({31'h0, irq}, 32'h00000000);
      end
      $display("test mask per bit done");
      for (int i = 0; i < 24; i++) begin
         m = rng[7:0];
         wb(1'b1, MASK_REG_ADDR, {rng[31:8], m}, 4'hF, 1'b0, 32'h0);
         wb(1'b1, MASK_REG_ADDR, {24'h0, ~m}, 4'hE, 1'b0, 32'h0);
         wb(1'b1, 32'hFFFF0500, {24'h0, ~m}, 4'hF, 1'b1, 32'h0);
         flags <= rng[15:8];
         wb(1'b0, MASK_REG_ADDR, 32'h0, 4'hF, 1'b0, {24'h0, m});
         check({31'h0, irq}, {31'h0, |(flags & m & 8'h5B)});
      end
      wb(1'b0, 32'hFFFF050C, 32'h0, 4'hF, 1'b1, 32'h0);
      $display("test mask random done");
      for (int v = 0; v < 256; v++) begin
         wb(1'b1, MODE_REG_ADDR, {rng[31:8], v[7:0]}, 4'hF, 1'b0, 32'h0);
         wb(1'b0, MODE_REG_ADDR, 32'h0, 4'hF, 1'b0, {24'h0, v[7:0]});
         check({29'h0, opMode}, {29'h0, v[2:0]});
         check({31'h0, clkSel}, {31'h0, v[7]});
         check({31'h0, lpAct}, {31'h0, v[3] & v[5]});
         check({31'h0, lpPlus}, {31'h0, v[4:3] == 2'b11});
      end
      $display("test mode decode done");
      wb(1'b1, MODE_REG_ADDR, 32'h00000083, 4'hF, 1'b0, 32'h0);
      measHalf(h);
      measHalf(h);
      check(h, 100_000_000 / (2 * 512_000));
      // Freeze: nothing may move while clkEn is low
      clkEn <= 1'b0;
      @(posedge sys_clk);
      lvl     = convClk;
      irqHeld = irq;
      flags   <= ~flags;
      repeat (200) @(posedge sys_clk);
      check({31'h0, convClk}, {31'h0, lvl});
      check({31'h0, irq}, {31'h0, irqHeld});
      clkEn <= 1'b1;
      wb(1'b1, MODE_REG_ADDR, 32'h0000002B, 4'hF, 1'b0, 32'h0);
      measHalf(h);
      measHalf(h);
      check(h, 100_000_000 / (2 * 131_000));
      $display("test conversion clock done");
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      wb(1'b0, MASK_REG_ADDR, 32'h0, 4'hF, 1'b0, 32'h00000000);
      wb(1'b0, MODE_REG_ADDR, 32'h0, 4'hF, 1'b0, 32'h00000003);
      check({31'h0, irq}, 32'h00000000);
      $display("test mid-run reset done");
      conclude();
   end
endmodule
